// *** qrw_pkg.sv ***
// Shared constants, opcodes and decode helpers for the quad flash link.
// Assumes both ends run on one 250 MHz system clock.
package qrw_pkg;
	// Opcodes handled by the device
	localparam logic [7:0] OP_WREN = 8'h06;
	localparam logic [7:0] OP_RDSR = 8'h05;
	localparam logic [7:0] OP_QREAD = 8'heb;
	localparam logic [7:0] OP_QREAD4 = 8'hec;
	localparam logic [7:0] OP_WRAP = 8'h77;
	localparam logic [7:0] OP_PROG = 8'h02;
	localparam logic [7:0] OP_PROG4 = 8'h12;
	// Timing
	localparam int CLK_NS = 4;
	localparam int SCLK_NS = 48;
	localparam int HALF_CLKS = SCLK_NS / 2 / CLK_NS;
	localparam int TPP_NS = 4000;
	localparam int PROG_CLKS = TPP_NS / CLK_NS;
	localparam int DUMMY_CLKS = 4;
	localparam int MODE_CLKS = 2;
	localparam int PAGE_BYTES = 256;
	// Wrap setting: bit 2 disables, bits 1:0 select length
	localparam logic [2:0] WRAP_RESET = 3'h4;
	localparam int WRAP_DIS_POS = 4;
	localparam int WRAP_LEN_POS = 5;
	// Status byte layout
	localparam int SR_BUSY_POS = 0;
	localparam int SR_WEN_POS = 1;
	// Host register offsets
	localparam logic [7:0] HR_CMD = 8'h00;
	localparam logic [7:0] HR_ADDR = 8'h04;
	localparam logic [7:0] HR_LEN = 8'h08;
	localparam logic [7:0] HR_DATA = 8'h0c;
	localparam logic [7:0] HR_STAT = 8'h10;
	localparam logic [7:0] HR_CFG = 8'h14;

	// Opcode moves address and data on four lines
	function automatic logic is_quad(input logic [7:0] op);
		return op == OP_QREAD || op == OP_QREAD4 || op == OP_WRAP;
	endfunction

	// Opcode carries an address field
	function automatic logic has_addr(input logic [7:0] op);
		return is_quad(op) || op == OP_PROG || op == OP_PROG4;
	endfunction

	// Address field is 32 bits wide
	function automatic logic addr32(input logic [7:0] op, input logic a4);
		return op == OP_QREAD4 || op == OP_PROG4 || a4;
	endfunction

	// Serial clocks spent on the address field
	function automatic logic [5:0] addr_clks(input logic [7:0] op,
			input logic a4);
		logic [5:0] bits;
		bits = addr32(op, a4) ? 6'd32 : 6'd24;
		return is_quad(op) ? {2'b00, bits[5:2]} : bits;
	endfunction
endpackage

// *** qrw_if.sv ***
// Link between the host controller and the flash device.
// IO lines are pulled high when neither end drives them.
interface qrw_if;
	logic cs_n; // Chip select, low active
	logic sclk; // Serial clock from host
	logic [3:0] host_io_o; // Host line values
	logic [3:0] host_io_oe; // Host drives line
	logic [3:0] dev_io_o; // Device line values
	logic [3:0] dev_io_oe; // Device drives line
	logic [3:0] io; // Resolved line levels

	// Resolve each line from its enables
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			if (dev_io_oe[i])
				io[i] = dev_io_o[i];
			else if (host_io_oe[i])
				io[i] = host_io_o[i];
			else
				io[i] = 1'b1;
		end
	end

	modport dev (input cs_n, sclk, io, output dev_io_o, dev_io_oe);
	modport host (output cs_n, sclk, host_io_o, host_io_oe, input io);
endinterface

// *** qrw_sync.sv ***
// Two-flop synchroniser with edge detect for a vector of pin inputs.
// Inputs are asynchronous to CLK; edges come from the settled stage.
module qrw_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] INIT = '0
) (
	// Clock and reset
	input wire logic CLK,
	input wire logic RESET_N,
	// Pins and results
	input wire logic [W-1:0] PIN,
	output logic [W-1:0] LVL,
	output logic [W-1:0] RISE,
	output logic [W-1:0] FALL
);
	logic [W-1:0] s1; // First stage, read only by s2
	logic [W-1:0] s2; // Settled level
	logic [W-1:0] s3; // Previous settled level

	// Synchroniser chain
	always_ff @(posedge CLK) begin
		if (!RESET_N) begin
			s1 <= INIT;
			s2 <= INIT;
			s3 <= INIT;
		end else begin
			s1 <= PIN;
			s2 <= s1;
			s3 <= s2;
		end
	end

	assign LVL = s2;
	assign RISE = s2 & ~s3;
	assign FALL = ~s2 & s3;
endmodule

// *** qrw_dev.sv ***
// Flash device end: quad read with wrap, wrap setting, page program.
// Link pins are sampled on CLK; serial clock must be slow enough
// for two-flop sampling. Protection arrives as a per-page lock map.
//
// The register offsets and the plain strobed port were chosen for this implementation.
module qrw_dev
	import qrw_pkg::*;
#(
	parameter int AW = 12
) (
	// System clock and reset
	input wire logic CLK,
	input wire logic RESET_N,
	// Link
	qrw_if.dev LNK,
	// Configuration
	input wire logic QUAD_ENABLE,
	input wire logic ADDR4_MODE,
	input wire logic [(1<<(AW-8))-1:0] PAGE_LOCK,
	// Status
	output logic BUSY,
	output logic WR_EN_LATCH,
	output logic [2:0] WRAP_SETTING
);
	import qrw_pkg::*;

	// Command phases
	typedef enum logic [3:0] {
		P_CMD = 4'h0, P_ADDR = 4'h1, P_MODE = 4'h2, P_DUMMY = 4'h3,
		P_RDATA = 4'h4, P_WRAPB = 4'h5, P_PDATA = 4'h6, P_STAT = 4'h7,
		P_WEN = 4'h8, P_IGNORE = 4'h9
	} qrw_ph_e;

	// All device state
	typedef struct packed {
		qrw_ph_e ph; // Current phase
		logic [5:0] cnt; // Serial clocks in phase
		logic [31:0] sh; // Input shifter
		logic [7:0] op; // Latched opcode
		logic [31:0] addr; // Read or program address
		logic [7:0] obyte; // Byte being sent
		logic nib; // Low nibble next
		logic [3:0] io_o; // Line values
		logic [3:0] io_oe; // Line enables
		logic [2:0] wrap; // Disable bit and length
		logic wen; // Write enable latch
		logic busy; // Program cycle running
		logic [10:0] pcnt; // Program cycle counter
		logic [7:0] col; // Page column for next byte
		logic got; // At least one data byte
		logic [PAGE_BYTES-1:0] wmask; // Columns written
	} qrw_dev_s;

	localparam qrw_dev_s DEV_RST = '{ph: P_CMD, wrap: WRAP_RESET,
		default: '0};

	qrw_dev_s r; // Registered state
	qrw_dev_s n; // Next state
	logic [7:0] mem [0:(1<<AW)-1]; // Flash array
	logic [7:0] pbuf [0:PAGE_BYTES-1]; // Page data buffer
	logic [5:0] lvl; // Synced cs_n, sclk, io
	logic [5:0] rise; // Rising edges
	logic [5:0] fall; // Falling edges
	logic [31:0] sh_in; // Shifter after this edge
	logic [31:0] wn; // Next read address
	logic quad; // Phase uses four lines
	logic buf_we; // Store a data byte
	logic mem_we; // Commit one byte to flash
	logic [AW-1:0] mem_wa; // Commit address

	// Next read address, looping inside the wrap section
	function automatic logic [31:0] wrap_next(input logic [31:0] a,
			input logic [2:0] w);
		logic [31:0] inc;
		logic [7:0] m;
		inc = a + 32'h1;
		m = (8'h08 << w[1:0]) - 8'h01;
		if (w[2])
			return inc;
		return {a[31:8], (a[7:0] & ~m) | (inc[7:0] & m)};
	endfunction

	// Erased flash reads all ones
	initial begin
		for (int i = 0; i < (1 << AW); i++)
			mem[i] = 8'hff;
	end

	// Link pin sampling; reset levels match idle pins, so no false edge
	qrw_sync #(.W(6), .INIT(6'h2f)) u_sync (
		.CLK(CLK),
		.RESET_N(RESET_N),
		.PIN({LNK.cs_n, LNK.sclk, LNK.io}),
		.LVL(lvl),
		.RISE(rise),
		.FALL(fall)
	);

	assign wn = wrap_next(r.addr, r.wrap);
	assign quad = is_quad(r.op) && r.ph != P_CMD;
	assign sh_in = quad ? {r.sh[27:0], lvl[3:0]} : {r.sh[30:0], lvl[0]};
	assign mem_wa = {r.addr[AW-1:8], r.pcnt[7:0]};

	// Next-state logic
	always_comb begin
		n = r;
		buf_we = 1'b0;
		mem_we = 1'b0;
		// Self-timed program cycle
		if (r.busy) begin
			n.pcnt = r.pcnt + 11'd1;
			mem_we = r.pcnt < 11'(PAGE_BYTES) && r.wmask[r.pcnt[7:0]];
			if (r.pcnt == 11'(PROG_CLKS - 1)) begin
				n.busy = 1'b0;
				n.wen = 1'b0;
			end
		end
		if (rise[5]) begin
			// Deselect ends the command
			n.ph = P_CMD;
			n.cnt = '0;
			n.io_oe = 4'h0;
			if (r.ph == P_WEN)
				n.wen = 1'b1;
			// Start only on a byte boundary with data, unlocked
			if (r.ph == P_PDATA && r.cnt == '0 && r.got &&
					!PAGE_LOCK[r.addr[AW-1:8]]) begin
				n.busy = 1'b1;
				n.pcnt = '0;
			end
		end else if (!lvl[5] && rise[4]) begin
			n.sh = sh_in;
			n.cnt = r.cnt + 6'd1;
			unique case (r.ph)
				P_CMD: if (r.cnt == 6'd7) begin
					n.op = sh_in[7:0];
					n.cnt = '0;
					if (r.busy && sh_in[7:0] != OP_RDSR)
						n.ph = P_IGNORE;
					else if (sh_in[7:0] == OP_RDSR) begin
						n.ph = P_STAT;
						n.obyte = '0;
						n.obyte[SR_BUSY_POS] = r.busy;
						n.obyte[SR_WEN_POS] = r.wen;
					end else if (sh_in[7:0] == OP_WREN)
						n.ph = P_WEN;
					else if (is_quad(sh_in[7:0]) && sh_in[7:0] != OP_WRAP)
						n.ph = QUAD_ENABLE ? P_ADDR : P_IGNORE;
					else if (sh_in[7:0] == OP_WRAP)
						n.ph = P_ADDR;
					else if (sh_in[7:0] == OP_PROG || sh_in[7:0] == OP_PROG4)
						n.ph = r.wen ? P_ADDR : P_IGNORE;
					else
						n.ph = P_IGNORE;
				end
				P_ADDR: if (r.cnt == addr_clks(r.op, ADDR4_MODE) - 6'd1) begin
					// Address width by opcode and mode
					n.addr = addr32(r.op, ADDR4_MODE) ? sh_in
						: {8'h00, sh_in[23:0]};
					n.cnt = '0;
					n.col = sh_in[7:0];
					n.got = 1'b0;
					n.wmask = '0;
					if (r.op == OP_WRAP)
						n.ph = P_WRAPB;
					else if (is_quad(r.op))
						n.ph = P_MODE;
					else
						n.ph = P_PDATA;
				end
				P_MODE: if (r.cnt == 6'(MODE_CLKS - 1)) begin
					n.ph = P_DUMMY; // Mode bits are not used
					n.cnt = '0;
				end
				P_DUMMY: if (r.cnt == 6'(DUMMY_CLKS - 1)) begin
					n.ph = P_RDATA;
					n.obyte = mem[r.addr[AW-1:0]];
					n.nib = 1'b0;
				end
				P_RDATA: begin
					n.nib = !r.nib;
					if (r.nib) begin
						n.addr = wn;
						n.obyte = mem[wn[AW-1:0]];
					end
				end
				P_WRAPB: if (r.cnt == 6'd1) begin
					// Bit 7 and low nibble ignored
					n.wrap = {sh_in[WRAP_DIS_POS],
						sh_in[WRAP_LEN_POS+1:WRAP_LEN_POS]};
					n.ph = P_IGNORE;
				end
				P_PDATA: if (r.cnt == 6'd7) begin
					buf_we = 1'b1;
					n.wmask[r.col] = 1'b1;
					n.col = r.col + 8'd1;
					n.got = 1'b1;
					n.cnt = '0;
				end
				P_STAT: begin
					n.obyte = {r.obyte[6:0], r.obyte[7]};
					if (r.cnt == 6'd7) begin
						n.cnt = '0;
						n.obyte = '0;
						n.obyte[SR_BUSY_POS] = r.busy;
						n.obyte[SR_WEN_POS] = r.wen;
					end
				end
				default: ;
			endcase
		end else if (!lvl[5] && fall[4]) begin
			// Outputs change after the falling edge
			if (r.ph == P_RDATA) begin
				n.io_o = r.nib ? r.obyte[3:0] : r.obyte[7:4];
				n.io_oe = 4'hf;
			end else if (r.ph == P_STAT) begin
				n.io_o = {2'b00, r.obyte[7], 1'b0};
				n.io_oe = 4'h2;
			end
		end
	end

	// State register
	always_ff @(posedge CLK) begin
		if (!RESET_N)
			r <= DEV_RST;
		else
			r <= n;
	end

	// Page buffer and array; plain always, as the array is preset erased
	always @(posedge CLK) begin
		if (buf_we)
			pbuf[r.col] <= sh_in[7:0];
		if (mem_we)
			mem[mem_wa] <= mem[mem_wa] & pbuf[r.pcnt[7:0]];
	end

	assign LNK.dev_io_o = r.io_o;
	assign LNK.dev_io_oe = r.io_oe;
	assign BUSY = r.busy;
	assign WR_EN_LATCH = r.wen;
	assign WRAP_SETTING = r.wrap;
endmodule

// *** qrw_host.sv ***
// Host controller end: drives chip select, serial clock and IO lines.
// Software loads registers over a plain strobe port; read data one
// cycle after the read strobe. IO inputs pass a two-flop synchroniser.
module qrw_host
	import qrw_pkg::*;
#(
	parameter int DEPTH = 16,
	parameter int HALF = HALF_CLKS
) (
	// System clock and reset
	input wire logic CLK,
	input wire logic RESET_N,
	// Register port
	input wire logic [7:0] ADDR,
	input wire logic [31:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [31:0] RDATA,
	// Link
	qrw_if.host LNK
);
	import qrw_pkg::*;

	localparam int IW = $clog2(DEPTH);

	// Transfer phases
	typedef enum logic [3:0] {
		H_IDLE = 4'h0, H_CMD = 4'h1, H_ADDR = 4'h2, H_MODE = 4'h3,
		H_DUMMY = 4'h4, H_RD = 4'h5, H_WR = 4'h6, H_END = 4'h7,
		H_GAP = 4'h8
	} qrw_hph_e;

	// All host state
	typedef struct packed {
		qrw_hph_e ph; // Current phase
		logic [3:0] div; // Half-period divider
		logic sclk; // Serial clock
		logic cs_n; // Chip select
		logic [31:0] sh; // Output shifter, msb first
		logic [7:0] rx; // Input shifter
		logic [5:0] rem; // Clocks left in unit
		logic [IW-1:0] idx; // Data byte index
		logic [3:0] io_o; // Line values
		logic [3:0] io_oe; // Line enables
		logic [7:0] op; // Opcode
		logic [31:0] addr; // Target address
		logic [IW-1:0] len; // Last data byte index
		logic a4; // Device is in 4-byte mode
		logic [IW-1:0] wp; // Buffer write pointer
		logic [IW-1:0] rp; // Buffer read pointer
		logic [31:0] rdata; // Read data
	} qrw_host_s;

	localparam qrw_host_s HOST_RST = '{ph: H_IDLE, cs_n: 1'b1,
		default: '0};

	qrw_host_s r; // Registered state
	qrw_host_s n; // Next state
	logic [7:0] dbuf [0:DEPTH-1]; // Data bytes in and out
	logic [3:0] io_s; // Synced IO levels
	logic qd; // Phase uses four lines
	logic tick; // Half period elapsed
	logic [7:0] rx_in; // Input shifter after sample
	logic [5:0] bclk; // Clocks per data byte
	logic buf_we; // Buffer write
	logic [IW-1:0] buf_wa; // Buffer write index
	logic [7:0] buf_wd; // Buffer write data

	// IO sampling
	qrw_sync #(.W(4), .INIT(4'hf)) u_sync (
		.CLK(CLK),
		.RESET_N(RESET_N),
		.PIN(LNK.io),
		.LVL(io_s),
		.RISE(),
		.FALL()
	);

	assign qd = is_quad(r.op) && r.ph != H_CMD;
	assign tick = r.div == 4'(HALF - 1);
	assign rx_in = qd ? {r.rx[3:0], io_s} : {r.rx[6:0], io_s[1]};
	assign bclk = qd ? 6'd2 : 6'd8;

	// Next-state logic
	always_comb begin
		n = r;
		buf_we = 1'b0;
		buf_wa = r.wp;
		buf_wd = WDATA[7:0];
		// Register reads
		if (RD) begin
			n.rdata = '0;
			unique case (ADDR)
				HR_CMD: n.rdata = {24'h0, r.op};
				HR_ADDR: n.rdata = r.addr;
				HR_LEN: n.rdata = 32'(r.len);
				HR_DATA: begin
					n.rdata = {24'h0, dbuf[r.rp]};
					n.rp = r.rp + 1'b1;
				end
				HR_STAT: n.rdata = {31'h0, r.ph != H_IDLE};
				HR_CFG: n.rdata = {31'h0, r.a4};
				default: ;
			endcase
		end
		// Register writes, ignored while a transfer runs
		if (WR && r.ph == H_IDLE) begin
			unique case (ADDR)
				HR_ADDR: n.addr = WDATA;
				HR_LEN: n.len = WDATA[IW-1:0];
				HR_DATA: begin
					buf_we = 1'b1;
					n.wp = r.wp + 1'b1;
				end
				HR_CFG: n.a4 = WDATA[0];
				HR_CMD: begin
					// Select, first opcode bit on the input line
					n.op = WDATA[7:0];
					n.ph = H_CMD;
					n.cs_n = 1'b0;
					n.sh = {WDATA[7:0], 24'h0};
					n.rem = 6'd8;
					n.idx = '0;
					n.div = '0;
					n.wp = '0;
					n.rp = '0;
					n.io_o = {3'b000, WDATA[7]};
					n.io_oe = 4'h1;
				end
				default: ;
			endcase
		end
		if (r.ph != H_IDLE) begin
			n.div = tick ? 4'h0 : r.div + 4'h1;
			// Deselect only once the serial clock is low again
			if (tick && r.ph == H_END && !r.sclk) begin
				n.ph = H_GAP;
				n.cs_n = 1'b1; // After last falling edge
			end else if (tick && r.ph == H_GAP)
				n.ph = H_IDLE;
			else if (tick && !r.sclk) begin
				// Rising edge: sample and advance
				n.sclk = 1'b1;
				n.rx = rx_in;
				n.sh = qd ? {r.sh[27:0], 4'h0} : {r.sh[30:0], 1'b0};
				n.rem = r.rem - 6'd1;
				if (r.rem == 6'd1) begin
					unique case (r.ph)
						H_CMD: if (r.op == OP_RDSR) begin
							n.ph = H_RD;
							n.rem = 6'd8;
						end else if (has_addr(r.op)) begin
							// 32-bit field when needed
							n.ph = H_ADDR;
							n.rem = addr_clks(r.op, r.a4);
							if (r.op == OP_WRAP)
								n.sh = '0;
							else if (addr32(r.op, r.a4))
								n.sh = r.addr;
							else
								n.sh = {r.addr[23:0], 8'h00};
						end else
							n.ph = H_END;
						H_ADDR: if (r.op == OP_QREAD || r.op == OP_QREAD4) begin
							n.ph = H_MODE;
							n.rem = 6'(MODE_CLKS);
							n.sh = {8'hff, 24'h0};
						end else begin
							n.ph = H_WR;
							n.rem = bclk;
							n.sh = {dbuf[0], 24'h0};
						end
						H_MODE: begin
							n.ph = H_DUMMY;
							n.rem = 6'(DUMMY_CLKS);
						end
						H_DUMMY: begin
							n.ph = H_RD;
							n.rem = bclk;
						end
						H_RD: begin
							buf_we = 1'b1;
							buf_wa = r.idx;
							buf_wd = rx_in;
							n.rem = bclk;
							n.idx = r.idx + 1'b1;
							if (r.idx == r.len)
								n.ph = H_END;
						end
						H_WR: begin
							n.rem = bclk;
							n.idx = r.idx + 1'b1;
							n.sh = {dbuf[r.idx + 1'b1], 24'h0};
							if (r.idx == r.len || r.op == OP_WRAP)
								n.ph = H_END; // Whole bytes only
						end
						default: ;
					endcase
				end
			end else if (tick) begin
				// Falling edge: present next bits
				n.sclk = 1'b0;
				n.io_o = qd ? r.sh[31:28] : {3'b000, r.sh[31]};
				n.io_oe = 4'h0; // Released in dummy and read
				if (r.ph == H_CMD || r.ph == H_ADDR || r.ph == H_MODE
						|| r.ph == H_WR)
					n.io_oe = qd ? 4'hf : 4'h1;
			end
		end
	end

	// State register
	always_ff @(posedge CLK) begin
		if (!RESET_N)
			r <= HOST_RST;
		else
			r <= n;
	end

	// Data buffer
	always_ff @(posedge CLK) begin
		if (buf_we)
			dbuf[buf_wa] <= buf_wd;
	end

	assign RDATA = r.rdata;
	assign LNK.cs_n = r.cs_n;
	assign LNK.sclk = r.sclk;
	assign LNK.host_io_o = r.io_o;
	assign LNK.host_io_oe = r.io_oe;
endmodule

// *** qrw_checker.sv ***
// Concurrent checks on the link wires and the device status outputs.
// Assumes one clock domain; placed beside the link interface in tb.
module qrw_checker
	import qrw_pkg::*;
(
	// Clock and reset
	input wire logic CLK,
	input wire logic RESET_N,
	// Link wires
	input wire logic cs_n,
	input wire logic sclk,
	input wire logic [3:0] host_io_oe,
	input wire logic [3:0] dev_io_oe,
	input wire logic [3:0] io,
	// Device status
	input wire logic BUSY,
	input wire logic WR_EN_LATCH,
	input wire logic [2:0] WRAP_SETTING
);
	logic [11:0] busy_len; // Cycles the current program cycle has run

	// Count busy cycles so the cycle length can be judged at its end
	always_ff @(posedge CLK) begin
		if (!RESET_N)
			busy_len <= 12'h0;
		else if (BUSY)
			busy_len <= busy_len + 12'h1;
		else
			busy_len <= 12'h0;
	end

	default clocking @(posedge CLK); endclocking
	default disable iff (!RESET_N);

	// Steps of a program cycle and of a quiet deselect
	sequence s_prog_start;
		$rose(BUSY);
	endsequence
	sequence s_prog_end;
		$fell(BUSY);
	endsequence
	sequence s_deselected;
		cs_n [*6];
	endsequence

	a_sclk_idle_low: assert property (cs_n |-> !sclk)
		else $error("serial clock not low while deselected");
	a_no_line_fight: assert property ((host_io_oe & dev_io_oe) == 4'h0)
		else $error("both ends drive a data line");
	a_dev_released: assert property (s_deselected |-> dev_io_oe == 4'h0)
		else $error("device drives lines while deselected");
	a_lines_float_high: assert property (s_deselected |-> io == 4'hf)
		else $error("data lines not pulled high while deselected");
	a_prog_needs_wen: assert property (s_prog_start |-> WR_EN_LATCH)
		else $error("program cycle began without write enable");
	a_busy_after_frame: assert property (s_prog_start |-> cs_n && $past(cs_n))
		else $error("program cycle began inside a frame");
	a_busy_length: assert property (s_prog_end |->
		busy_len >= 12'(PROG_CLKS - 1) && busy_len <= 12'(PROG_CLKS + 1))
		else $error("program cycle length wrong");
	a_wen_cleared: assert property (s_prog_end |-> !WR_EN_LATCH)
		else $error("write enable still set after program");
	a_wen_held: assert property (BUSY |-> WR_EN_LATCH)
		else $error("write enable dropped during program");
	a_wrap_reset: assert property ($rose(RESET_N) |-> WRAP_SETTING == 3'h4)
		else $error("wrap setting not disabled after reset");
	a_wrap_in_frame: assert property ($changed(WRAP_SETTING) |->
		!$past(cs_n) || !$past(cs_n, 4))
		else $error("wrap setting changed outside a frame");
endmodule

// *** tb.sv ***
// Self-checking bench: host and device face each other on the link.
// Drives the host register port and the device configuration pins.
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import qrw_pkg::*;

	logic clk; // System clock
	logic reset_n; // Synchronous reset, low active
	logic [7:0] addr; // Register address
	logic [31:0] wdata; // Register write data
	logic wr; // Write strobe
	logic rd; // Read strobe
	logic [31:0] rdata; // Register read data
	logic quad_en; // Quad enable level
	logic addr4; // Four-byte address mode
	logic [15:0] page_lock; // Per-page protection map
	logic busy; // Program cycle running
	logic wr_en_latch; // Write enable latch
	logic [2:0] wrap_setting; // Wrap disable and length
	logic [31:0] got; // Last register read value
	int error_cnt = 0; // Mismatches
	int samples_checked = 0; // Comparisons made
	int cyc = 0; // Cycle count for the hang guard

	qrw_if lnk();
	qrw_dev #(.AW(12)) u_qrw_dev (.CLK(clk), .RESET_N(reset_n), .LNK(lnk),
		.QUAD_ENABLE(quad_en), .ADDR4_MODE(addr4), .PAGE_LOCK(page_lock),
		.BUSY(busy), .WR_EN_LATCH(wr_en_latch), .WRAP_SETTING(wrap_setting));
	qrw_host u_qrw_host (.CLK(clk), .RESET_N(reset_n), .ADDR(addr),
		.WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .LNK(lnk));
	qrw_checker u_qrw_checker (.CLK(clk), .RESET_N(reset_n),
		.cs_n(lnk.cs_n), .sclk(lnk.sclk), .host_io_oe(lnk.host_io_oe),
		.dev_io_oe(lnk.dev_io_oe), .io(lnk.io), .BUSY(busy),
		.WR_EN_LATCH(wr_en_latch),
		.WRAP_SETTING(wrap_setting));

	// Free-running system clock
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	// Print counts and verdict, then stop
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// Hang guard: far beyond the expected run length
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			error_cnt++;
			give_verdict();
		end
	end

	// Compare and report one value
	task automatic chk(input string name, input logic [31:0] exp,
			input logic [31:0] act);
		samples_checked++;
		if (act !== exp) begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", name, exp, act);
		end
	endtask

	// One-cycle register write
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	// One-cycle register read; data taken in the following cycle
	task automatic rd_reg(input logic [7:0] a);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 got = rdata;
	endtask

	// Start a transfer and poll until the host is idle again
	task automatic run(input logic [7:0] op);
		int n;
		n = 0;
		wr_reg(HR_CMD, {24'h0, op});
		do begin
			rd_reg(HR_STAT);
			n++;
		end while (got[0] !== 1'b0 && n < 3000);
		chk("transfer done", 32'h0, {31'h0, got[0]});
	endtask

	// Wait, bounded, for the program cycle to end
	task automatic wait_idle();
		for (int n = 0; n < 1500 && busy !== 1'b0; n++)
			@(posedge clk);
		chk("program end", 32'h0, {31'h0, busy});
	endtask

	// Read four bytes and compare them, first byte in the top lane
	task automatic read4(input logic [7:0] op, input logic [31:0] a,
			input logic [31:0] e);
		wr_reg(HR_ADDR, a);
		wr_reg(HR_LEN, 32'h3);
		run(op);
		for (int i = 0; i < 4; i++) begin
			rd_reg(HR_DATA);
			chk("read byte", {24'h0, e[31-8*i -: 8]}, {24'h0, got[7:0]});
		end
	endtask

	// Load n data bytes and send a program command
	task automatic prog(input logic [7:0] op, input logic [31:0] a,
			input int n, input logic [31:0] d);
		wr_reg(HR_ADDR, a);
		wr_reg(HR_LEN, 32'(n - 1));
		for (int i = 0; i < n; i++)
			wr_reg(HR_DATA, {24'h0, d[31-8*i -: 8]});
		run(op);
	endtask

	// Send a wrap setting; byte loaded as both address and data
	task automatic set_wrap(input logic [7:0] w);
		wr_reg(HR_ADDR, {24'h0, w});
		wr_reg(HR_LEN, 32'h0);
		wr_reg(HR_DATA, {24'h0, w});
		run(OP_WRAP);
	endtask

	// Main sequence
	initial begin
		reset_n = 1'b0;
		addr = 8'h0;
		wdata = 32'h0;
		wr = 1'b0;
		rd = 1'b0;
		quad_en = 1'b1;
		addr4 = 1'b0;
		page_lock = 16'h0;
		got = 32'h0;
		repeat (2) @(posedge clk);
		reset_n <= 1'b1;
		repeat (4) @(posedge clk);
		chk("wrap after reset", 32'h4, {29'h0, wrap_setting});
		chk("busy after reset", 32'h0, {31'h0, busy});
		// Program four bytes from 0feh; the last two wrap to the start of the page
		run(OP_WREN);
		chk("latch set", 32'h1, {31'h0, wr_en_latch});
		prog(OP_PROG, 32'h0fe, 4, 32'hd0d1d2d3);
		chk("busy in program", 32'h1, {31'h0, busy});
		wr_reg(HR_LEN, 32'h0);
		run(OP_RDSR);
		rd_reg(HR_DATA);
		chk("status in program", 32'h3, {30'h0, got[1:0]});
		wait_idle();
		chk("latch cleared", 32'h0, {31'h0, wr_en_latch});
		read4(OP_QREAD, 32'h000, 32'hd2d3ffff);
		// Every wrap length, unused bits set
		for (int i = 0; i < 4; i++) begin
			set_wrap({1'b1, 2'(i), 1'b0, 4'hf});
			chk("wrap setting", 32'(i), {29'h0, wrap_setting});
		end
		set_wrap(8'h8f);
		// Eight-byte section: 06h, 07h, then back to 00h and 01h
		read4(OP_QREAD, 32'h006, 32'hffffd2d3);
		read4(OP_QREAD4, 32'h006, 32'hffffd2d3);
		set_wrap(8'h70);
		chk("wrap off", 32'h7, {29'h0, wrap_setting});
		// Linear past the 64-byte mark; a wrap would return 00h data
		read4(OP_QREAD, 32'h03e, 32'hffffffff);
		// Quad read refused without quad enable
		@(posedge clk);
		quad_en <= 1'b0;
		read4(OP_QREAD, 32'h0fe, 32'hffffffff);
		@(posedge clk);
		quad_en <= 1'b1;
		page_lock <= 16'h0002;
		// Locked page skipped, latch kept
		run(OP_WREN);
		prog(OP_PROG, 32'h100, 1, 32'h5a000000);
		chk("busy on locked", 32'h0, {31'h0, busy});
		chk("latch on locked", 32'h1, {31'h0, wr_en_latch});
		@(posedge clk);
		page_lock <= 16'h0;
		prog(OP_PROG4, 32'h100, 1, 32'h5a000000);
		wait_idle();
		// Program without write enable is ignored
		prog(OP_PROG, 32'h101, 1, 32'h11000000);
		chk("busy without latch", 32'h0, {31'h0, busy});
		read4(OP_QREAD4, 32'h100, 32'h5affffff);
		// Four-byte address mode
		@(posedge clk);
		addr4 <= 1'b1;
		wr_reg(HR_CFG, 32'h1);
		read4(OP_QREAD, 32'h0fe, 32'hd0d15aff);
		set_wrap(8'h10);
		chk("wrap in wide mode", 32'h4, {29'h0, wrap_setting});
		give_verdict();
	end
endmodule
